/* File: rtl/tis_top.sv */
// threshold compare, sticky interrupt status and serial register access
`timescale 1ns/1ps
module tis_top #(
    parameter logic [6:0] SLAVE_ADDR = tis_pkg::DEFAULT_SLAVE_ADDR
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic int_n,
    input wire logic meas_clock,
    input wire logic prox_valid,
    input wire logic [15:0] prox_value,
    input wire logic als_valid,
    input wire logic [15:0] als_value,
    output logic [2:0] mod_delay,
    output logic [1:0] mod_freq,
    output logic [2:0] mod_dead
);
    import tis_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        logic scl_s1, scl_s2, scl_s3;
        logic sda_s1, sda_s2, sda_s3;
        logic req_s1, req_s2, req_s3;
        logic ack;
        tis_bus_e mode;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] tx;
        logic [7:0] ptr;
        logic rw;
        logic have_ptr;
        logic oe;
        logic [15:0] low_thr;
        logic [15:0] high_thr;
        logic [7:0] ctrl;
        logic [7:0] timing;
        logic [3:0] flags;
        logic [7:0] persist;
        logic int_n;
    } tis_state_s;

    tis_state_s q;
    tis_state_s n;

    logic link_toggle, link_prox_v, link_als_v;
    logic [15:0] link_prox, link_als;
    logic scl_rise, scl_fall, bus_start, bus_stop;
    logic [7:0] rd_byte, wr_data;
    logic wr_fire, new_xfer, sel_v, meas_ev, below_hit, above_hit, fire;
    logic [15:0] sel_val;
    logic [7:0] need, persist_inc;
    logic [3:0] set, clr;

    // ==========================================================
    // measurement crossing
    tis_meas_link u_link (
        .meas_clock(meas_clock),
        .sys_rst(sys_rst),
        .prox_valid(prox_valid),
        .prox_value(prox_value),
        .als_valid(als_valid),
        .als_value(als_value),
        .link_ack(q.ack),
        .link_toggle(link_toggle),
        .link_prox_v(link_prox_v),
        .link_als_v(link_als_v),
        .link_prox(link_prox),
        .link_als(link_als)
    );

    // ==========================================================
    // pin edges, from the second and third stage only
    assign scl_rise = q.scl_s2 & ~q.scl_s3;
    assign scl_fall = ~q.scl_s2 & q.scl_s3;
    assign bus_start = q.scl_s2 & q.scl_s3 & ~q.sda_s2 & q.sda_s3;
    assign bus_stop = q.scl_s2 & q.scl_s3 & q.sda_s2 & ~q.sda_s3;

    // ==========================================================
    // register read mux, unmapped reads return zero
    always_comb begin
        case (q.ptr)
            ADDR_CTRL: rd_byte = q.ctrl;
            ADDR_LOW_UPPER: rd_byte = q.low_thr[15:8];
            ADDR_LOW_LOWER: rd_byte = q.low_thr[7:0];
            ADDR_HIGH_UPPER: rd_byte = q.high_thr[15:8];
            ADDR_HIGH_LOWER: rd_byte = q.high_thr[7:0];
            ADDR_STATUS: rd_byte = {4'h0, q.flags};
            ADDR_TIMING: rd_byte = q.timing;
            default: rd_byte = 8'h00;
        endcase
    end

    // ==========================================================
    // threshold evaluation
    assign new_xfer = q.req_s2 ^ q.req_s3;
    assign sel_v = q.ctrl[CTRL_SOURCE_SEL] ? link_als_v : link_prox_v;
    assign sel_val = q.ctrl[CTRL_SOURCE_SEL] ? link_als : link_prox;
    assign meas_ev = new_xfer & sel_v;
    assign below_hit = sel_val < q.low_thr;
    assign above_hit = sel_val > q.high_thr;
    assign need = 8'h01 << q.ctrl[CTRL_COUNT_LSB +: 3];
    assign persist_inc = q.persist + 8'h01;
    assign fire = persist_inc >= need;
    assign wr_data = q.sh;
    // kept outside the next-state process so the clear path has no loop through it
    assign wr_fire = (q.mode == TIS_RX) && scl_fall && (q.cnt == I2C_BITS) && q.have_ptr;

    always_comb begin
        set = 4'h0;
        if (meas_ev && q.ctrl[CTRL_THR_EN] && fire) begin
            // above wins if the window is programmed inverted
            if (above_hit) begin
                set[BIT_ABOVE] = 1'b1;
            end else if (below_hit) begin
                set[BIT_BELOW] = 1'b1;
            end
        end
        if (new_xfer && link_prox_v && q.ctrl[CTRL_PROX_EN]) begin
            set[BIT_PROX_READY] = 1'b1;
        end
        if (new_xfer && link_als_v && q.ctrl[CTRL_ALS_EN]) begin
            set[BIT_ALS_READY] = 1'b1;
        end
    end

    assign clr = (wr_fire && q.ptr == ADDR_STATUS) ? wr_data[3:0] : 4'h0;

    // ==========================================================
    // next state
    always_comb begin
        n = q;
        n.scl_s1 = scl_in;
        n.scl_s2 = q.scl_s1;
        n.scl_s3 = q.scl_s2;
        n.sda_s1 = sda_in;
        n.sda_s2 = q.sda_s1;
        n.sda_s3 = q.sda_s2;
        n.req_s1 = link_toggle;
        n.req_s2 = q.req_s1;
        n.req_s3 = q.req_s2;
        // link words were stable two edges before the toggle shows here
        if (new_xfer) begin
            n.ack = q.req_s2;
        end

        case (q.mode)
            TIS_IDLE: begin
                n.oe = 1'b0;
            end
            TIS_ADDR: begin
                if (scl_rise) begin
                    n.sh = {q.sh[6:0], q.sda_s2};
                    n.cnt = q.cnt + 4'h1;
                end else if (scl_fall && q.cnt == I2C_BITS) begin
                    if (q.sh[7:1] == SLAVE_ADDR) begin
                        n.rw = q.sh[0];
                        n.have_ptr = 1'b0;
                        n.oe = 1'b1;
                        n.mode = TIS_ACK;
                    end else begin
                        n.mode = TIS_IDLE;
                    end
                end
            end
            TIS_ACK: begin
                if (scl_fall) begin
                    n.cnt = 4'h0;
                    if (q.rw) begin
                        n.tx = rd_byte;
                        n.ptr = q.ptr + 8'h01;
                        n.oe = ~rd_byte[7];
                        n.mode = TIS_TX;
                    end else begin
                        n.oe = 1'b0;
                        n.mode = TIS_RX;
                    end
                end
            end
            TIS_RX: begin
                if (scl_rise) begin
                    n.sh = {q.sh[6:0], q.sda_s2};
                    n.cnt = q.cnt + 4'h1;
                end else if (scl_fall && q.cnt == I2C_BITS) begin
                    // first byte of a write only moves the pointer
                    n.ptr = q.have_ptr ? q.ptr + 8'h01 : q.sh;
                    n.have_ptr = 1'b1;
                    n.oe = 1'b1;
                    n.mode = TIS_ACK;
                end
            end
            TIS_TX: begin
                if (scl_fall) begin
                    n.cnt = q.cnt + 4'h1;
                    if (q.cnt == I2C_BITS - 4'h1) begin
                        n.oe = 1'b0;
                        n.mode = TIS_MACK;
                    end else begin
                        n.tx = {q.tx[6:0], 1'b0};
                        n.oe = ~q.tx[6];
                    end
                end
            end
            TIS_MACK: begin
                if (scl_rise && q.sda_s2) begin
                    n.mode = TIS_IDLE;
                end else if (scl_fall) begin
                    n.tx = rd_byte;
                    n.ptr = q.ptr + 8'h01;
                    n.oe = ~rd_byte[7];
                    n.cnt = 4'h0;
                    n.mode = TIS_TX;
                end
            end
            default: begin
                n.oe = 1'b0;
                n.mode = TIS_IDLE;
            end
        endcase
        if (bus_start) begin
            n.mode = TIS_ADDR;
            n.cnt = 4'h0;
            n.oe = 1'b0;
        end else if (bus_stop) begin
            n.mode = TIS_IDLE;
            n.oe = 1'b0;
        end

        // register writes
        if (wr_fire) begin
            case (q.ptr)
                ADDR_CTRL: n.ctrl = wr_data;
                ADDR_LOW_UPPER: n.low_thr[15:8] = wr_data;
                ADDR_LOW_LOWER: n.low_thr[7:0] = wr_data;
                ADDR_HIGH_UPPER: n.high_thr[15:8] = wr_data;
                ADDR_HIGH_LOWER: n.high_thr[7:0] = wr_data;
                ADDR_TIMING: n.timing = wr_data;
                default: n.ctrl = q.ctrl;
            endcase
        end

        // consecutive out-of-window run, restarted after each flag
        if (!q.ctrl[CTRL_THR_EN]) begin
            n.persist = 8'h00;
        end else if (meas_ev) begin
            if (!(below_hit || above_hit) || fire) begin
                n.persist = 8'h00;
            end else begin
                n.persist = persist_inc;
            end
        end

        // a set in the clearing cycle survives
        n.flags = (q.flags & ~clr) | set;
        n.int_n = ~|n.flags;

        if (sys_rst) begin
            n = '0;
            n.scl_s1 = 1'b1;
            n.scl_s2 = 1'b1;
            n.scl_s3 = 1'b1;
            n.sda_s1 = 1'b1;
            n.sda_s2 = 1'b1;
            n.sda_s3 = 1'b1;
            n.mode = TIS_IDLE;
            n.low_thr = RST_THRESHOLD;
            n.high_thr = RST_THRESHOLD;
            n.ctrl = RST_CTRL;
            n.timing = RST_TIMING;
            n.flags = RST_FLAGS;
            n.int_n = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        q <= n;
    end

    // ==========================================================
    // outputs; modulator fields feed the analog front end directly
    assign sda_out = 1'b0;
    assign sda_oe = q.oe;
    assign int_n = q.int_n;
    assign mod_delay = q.timing[TIM_DELAY_LSB +: 3];
    assign mod_freq = q.timing[TIM_FREQ_LSB +: 2];
    // larger dead time: less disturbance, smaller signal
    assign mod_dead = q.timing[TIM_DEAD_LSB +: 3];

    // ==========================================================
    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    int_level_a: assert property (
        int_n == (q.flags == 4'h0))
        else $error("interrupt pin disagrees with flags");

    sticky_flag_a: assert property (
        ($past(q.flags) & ~$past(clr) & ~q.flags) == 4'h0)
        else $error("flag dropped without a clear");

    clear_only_a: assert property (
        clr != 4'h0 |=> (q.flags & ~$past(set)) ==
            ($past(q.flags) & ~$past(clr) & ~$past(set)))
        else $error("clear touched wrong flags");

    low_write_a: assert property (
        (wr_fire && q.ptr == ADDR_LOW_UPPER) |=> q.low_thr[15:8] == $past(wr_data))
        else $error("low threshold upper byte not stored");

    high_write_a: assert property (
        (wr_fire && q.ptr == ADDR_HIGH_LOWER) |=> q.high_thr[7:0] == $past(wr_data))
        else $error("high threshold lower byte not stored");

    timing_reset_a: assert property (
        $past(sys_rst) |-> q.timing == RST_TIMING)
        else $error("timing register reset value wrong");

    status_read_a: assert property (
        q.ptr == ADDR_STATUS |-> rd_byte == {4'h0, q.flags})
        else $error("status read layout wrong");

    thr_gate_a: assert property (
        !q.ctrl[CTRL_THR_EN] |=> (q.flags[1:0] & ~$past(q.flags[1:0])) == 2'b00)
        else $error("threshold flag raised while disabled");

    above_set_a: assert property (
        (meas_ev && q.ctrl[CTRL_THR_EN] && fire && above_hit) |=> q.flags[BIT_ABOVE])
        else $error("above flag not raised");

    below_set_a: assert property (
        (meas_ev && q.ctrl[CTRL_THR_EN] && fire && below_hit && !above_hit)
            |=> q.flags[BIT_BELOW])
        else $error("below flag not raised");

    run_count_a: assert property (
        (meas_ev && q.ctrl[CTRL_THR_EN] && (below_hit || above_hit) && !fire)
            |=> q.persist == $past(persist_inc) && q.flags[1:0] == $past(q.flags[1:0] & ~clr[1:0]))
        else $error("consecutive count wrong");

    ready_set_a: assert property (
        (new_xfer && link_prox_v && q.ctrl[CTRL_PROX_EN]) |=> q.flags[BIT_PROX_READY])
        else $error("proximity ready flag not raised");

endmodule // tis_top

/* File: rtl/tis_pkg.sv */
// constants, types and register map of the threshold and interrupt status block
package tis_pkg;

    // ==========================================================
    // register addresses
    localparam logic [7:0] ADDR_CTRL = 8'h89;
    localparam logic [7:0] ADDR_LOW_UPPER = 8'h8a;
    localparam logic [7:0] ADDR_LOW_LOWER = 8'h8b;
    localparam logic [7:0] ADDR_HIGH_UPPER = 8'h8c;
    localparam logic [7:0] ADDR_HIGH_LOWER = 8'h8d;
    localparam logic [7:0] ADDR_STATUS = 8'h8e;
    localparam logic [7:0] ADDR_TIMING = 8'h8f;

    // ==========================================================
    // field positions
    localparam int BIT_PROX_READY = 3;
    localparam int BIT_ALS_READY = 2;
    localparam int BIT_BELOW = 1;
    localparam int BIT_ABOVE = 0;
    localparam int CTRL_SOURCE_SEL = 0;
    localparam int CTRL_THR_EN = 1;
    localparam int CTRL_ALS_EN = 2;
    localparam int CTRL_PROX_EN = 3;
    localparam int CTRL_COUNT_LSB = 5;
    localparam int TIM_DELAY_LSB = 5;
    localparam int TIM_FREQ_LSB = 3;
    localparam int TIM_DEAD_LSB = 0;

    // ==========================================================
    // values after reset
    localparam logic [15:0] RST_THRESHOLD = 16'h0000;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_TIMING = 8'h01;
    localparam logic [3:0] RST_FLAGS = 4'h0;

    // ==========================================================
    // serial bus
    localparam logic [3:0] I2C_BITS = 4'h8;
    localparam logic [6:0] DEFAULT_SLAVE_ADDR = 7'h13;

    typedef enum logic [2:0] {
        TIS_IDLE = 3'b000,
        TIS_ADDR = 3'b001,
        TIS_ACK = 3'b010,
        TIS_RX = 3'b011,
        TIS_TX = 3'b100,
        TIS_MACK = 3'b101
    } tis_bus_e;

    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic ack_s1;
        logic ack_s2;
        logic req;
        logic prox_v;
        logic als_v;
        logic [15:0] prox;
        logic [15:0] als;
    } tis_link_s;

endpackage

/* File: rtl/tis_meas_link.sv */
// front-end side of the measurement crossing, on the measurement clock
`timescale 1ns/1ps
module tis_meas_link (
    input wire logic meas_clock,
    input wire logic sys_rst,
    input wire logic prox_valid,
    input wire logic [15:0] prox_value,
    input wire logic als_valid,
    input wire logic [15:0] als_value,
    input wire logic link_ack,
    output logic link_toggle,
    output logic link_prox_v,
    output logic link_als_v,
    output logic [15:0] link_prox,
    output logic [15:0] link_als
);
    import tis_pkg::*;

    tis_link_s q;
    tis_link_s n;

    // ==========================================================
    // toggle handshake; results arriving while busy are dropped
    always_comb begin
        n = q;
        n.rst_s1 = sys_rst;
        n.rst_s2 = q.rst_s1;
        n.ack_s1 = link_ack;
        n.ack_s2 = q.ack_s1;
        if (q.rst_s2) begin
            n.req = 1'b0;
            n.prox_v = 1'b0;
            n.als_v = 1'b0;
            n.prox = 16'h0000;
            n.als = 16'h0000;
        end else if ((q.req == q.ack_s2) && (prox_valid || als_valid)) begin
            // words only change while the other side is not looking
            n.prox_v = prox_valid;
            n.als_v = als_valid;
            if (prox_valid) begin
                n.prox = prox_value;
            end
            if (als_valid) begin
                n.als = als_value;
            end
            n.req = ~q.req;
        end
    end

    always_ff @(posedge meas_clock) begin
        q <= n;
    end

    assign link_toggle = q.req;
    assign link_prox_v = q.prox_v;
    assign link_als_v = q.als_v;
    assign link_prox = q.prox;
    assign link_als = q.als;

endmodule // tis_meas_link

/* File: tb/tis_host_model.sv */
// serial bus host model: start, stop and byte transfers
`timescale 1ns/1ps
module tis_host_model (
    input wire logic clock,
    input wire logic sda_line,
    output logic scl,
    output logic sda_pull
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // ==========================================================
    // bus primitives
    // scl high 6 clocks and low 8 (6 plus 2), just above the 5 clock minimum
    task automatic hold(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic start_cond();
        sda_pull <= 1'b0;
        hold(6);
        scl <= 1'b1;
        hold(6);
        sda_pull <= 1'b1;
        hold(6);
        scl <= 1'b0;
        hold(2);
    endtask
    task automatic stop_cond();
        sda_pull <= 1'b1;
        hold(6);
        scl <= 1'b1;
        hold(6);
        sda_pull <= 1'b0;
        hold(6);
    endtask
    // data moves 2 clocks after the fall, before the device answers at 3
    task automatic bit_xfer(input logic b, output logic r);
        sda_pull <= ~b;
        hold(6);
        scl <= 1'b1;
        hold(6);
        r = sda_line;
        scl <= 1'b0;
        hold(2);
    endtask
    task automatic byte_out(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], r);
        end
        bit_xfer(1'b1, r);
        ack = ~r;
    endtask
    task automatic byte_in(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, r);
            d[i] = r;
        end
        bit_xfer(last, r);
    endtask
endmodule // tis_host_model

/* File: tb/tb_top.sv */
// self-checking bench of the threshold and interrupt status block
`timescale 1ns/1ps
module tb_top;
    import tis_pkg::*;
    logic clock = 1'b0;
    logic meas_clock = 1'b0;
    logic sys_rst = 1'b1;
    logic scl, sda_pull, sda_out, sda_oe, int_n;
    tri1 sda_line;
    logic prox_valid = 1'b0;
    logic als_valid = 1'b0;
    logic [15:0] prox_value = 16'h0000;
    logic [15:0] als_value = 16'h0000;
    logic [2:0] mod_delay, mod_dead;
    logic [1:0] mod_freq;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int cnt = 0;
    logic [15:0] lfsr = 16'h699e;
    logic [7:0] mreg [0:7];
    logic [3:0] mflags = 4'h0;

    always #12.5 clock = ~clock;
    // link clock free-running, phase unrelated to the system clock
    initial begin
        #7;
        forever #62.5 meas_clock = ~meas_clock;
    end
    assign sda_line = sda_pull ? 1'b0 : (sda_oe ? sda_out : 1'bz);

    tis_top i_tis_top (.clock(clock), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .int_n(int_n), .meas_clock(meas_clock),
        .prox_valid(prox_valid), .prox_value(prox_value), .als_valid(als_valid),
        .als_value(als_value), .mod_delay(mod_delay), .mod_freq(mod_freq),
        .mod_dead(mod_dead));
    tis_host_model i_tis_host_model (.clock(clock), .sda_line(sda_line), .scl(scl),
        .sda_pull(sda_pull));

    // ==========================================================
    // helpers and reference model
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] exp_reg(input logic [7:0] a);
        if (a == ADDR_STATUS) return {4'h0, mflags};
        if (a >= ADDR_CTRL && a <= ADDR_TIMING) return mreg[a[2:0]];
        return 8'h00;
    endfunction
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        logic k1, k2, k3;
        i_tis_host_model.start_cond();
        i_tis_host_model.byte_out({DEFAULT_SLAVE_ADDR, 1'b0}, k1);
        i_tis_host_model.byte_out(a, k2);
        i_tis_host_model.byte_out(d, k3);
        i_tis_host_model.stop_cond();
        chk("write ack", 16'h0001, {15'h0000, k1 & k2 & k3});
        if (a == ADDR_STATUS) mflags = mflags & ~d[3:0];
        else if (a >= ADDR_CTRL && a <= ADDR_TIMING) mreg[a[2:0]] = d;
    endtask
    // nb bytes in one read, the pointer stepping by one per byte
    task automatic check_reg(input logic [7:0] a, input int nb = 1);
        logic k1, k2, k3;
        logic [7:0] d;
        i_tis_host_model.start_cond();
        i_tis_host_model.byte_out({DEFAULT_SLAVE_ADDR, 1'b0}, k1);
        i_tis_host_model.byte_out(a, k2);
        i_tis_host_model.start_cond();
        i_tis_host_model.byte_out({DEFAULT_SLAVE_ADDR, 1'b1}, k3);
        for (int j = 0; j < nb; j++) begin
            i_tis_host_model.byte_in(j == nb - 1, d);
            chk($sformatf("reg %h", a + 8'(j)), {8'h00, exp_reg(a + 8'(j))}, {8'h00, d});
        end
        i_tis_host_model.stop_cond();
        chk("read ack", 16'h0001, {15'h0000, k1 & k2 & k3});
    endtask
    // one result, then the status and the pin against the model
    task automatic meas(input logic src, input logic [15:0] v);
        logic [15:0] lo, hi;
        @(posedge meas_clock);
        if (src) begin
            als_valid <= 1'b1;
            als_value <= v;
        end else begin
            prox_valid <= 1'b1;
            prox_value <= v;
        end
        @(posedge meas_clock);
        als_valid <= 1'b0;
        prox_valid <= 1'b0;
        repeat (10) @(posedge meas_clock);
        if (mreg[1][CTRL_PROX_EN - src]) mflags[BIT_PROX_READY - src] = 1'b1;
        if (mreg[1][CTRL_THR_EN] && mreg[1][CTRL_SOURCE_SEL] == src) begin
            lo = {mreg[2], mreg[3]};
            hi = {mreg[4], mreg[5]};
            if (v > hi || v < lo) begin
                cnt++;
                if (cnt >= (1 << mreg[1][7:5])) begin
                    mflags[v > hi ? BIT_ABOVE : BIT_BELOW] = 1'b1;
                    cnt = 0;
                end
            end else begin
                cnt = 0;
            end
        end
        check_reg(ADDR_STATUS);
        chk("int_n", {15'h0000, mflags == 4'h0}, {15'h0000, int_n});
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ==========================================================
    // hang guard, about one and a half times the expected run
    always @(posedge clock) begin
        cycles++;
        if (cycles == 90000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        logic k;
        // longer than 15 cycles so the link side sees three edges of its own
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clock);
        mreg = '{default: 8'h00};
        mreg[7] = RST_TIMING;
        for (int a = 8'h89; a <= 8'h90; a++) begin
            check_reg(8'(a));
        end
        chk("mod fields", {8'h00, RST_TIMING}, {8'h00, mod_delay, mod_freq, mod_dead});
        chk("int_n", 16'h0001, {15'h0000, int_n});
        i_tis_host_model.start_cond();
        i_tis_host_model.byte_out({DEFAULT_SLAVE_ADDR ^ 7'h01, 1'b0}, k);
        i_tis_host_model.stop_cond();
        chk("foreign address ack", 16'h0000, {15'h0000, k});
        $display("test reset values done");
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_next(lfsr);
            reg_write(ADDR_LOW_UPPER + 8'(i % 6), lfsr[7:0]);
            check_reg(ADDR_LOW_UPPER + 8'(i % 6), 2);
        end
        reg_write(8'h90, 8'h5a);
        check_reg(8'h90);
        chk("mod fields", {8'h00, mreg[7]}, {8'h00, mod_delay, mod_freq, mod_dead});
        $display("test registers done");
        reg_write(ADDR_LOW_UPPER, 8'h40);
        reg_write(ADDR_LOW_LOWER, 8'h00);
        reg_write(ADDR_HIGH_UPPER, 8'hc0);
        reg_write(ADDR_HIGH_LOWER, 8'h00);
        for (int r = 0; r < 5; r++) begin
            lfsr = lfsr_next(lfsr);
            reg_write(ADDR_CTRL, {3'(r % 3), 1'b0, r == 4 ? lfsr[3:0] & 4'hd : lfsr[3:0] | 4'h2});
            meas(1'b0, 16'h8000);
            meas(1'b1, 16'h8000);
            for (int n = 0; n < 10; n++) begin
                lfsr = lfsr_next(lfsr);
                meas(lfsr[0], lfsr);
                if (n % 3 == 2) reg_write(ADDR_STATUS, {4'h0, lfsr[7:4]});
            end
            $display("test flag round %0d done", r);
        end
        tally_and_finish();
    end
endmodule // tb_top
